// *** ssfp_port.sv ***
// Master framing logic of the synchronous serial frame port.
// Assumes the slave drives rxd from the serial clock made here; rxd is
// asynchronous to sys_clk and is synchronised before use.
`timescale 1ns/1ps

// Summary of operation
// - Frame length is programmed size, four to sixteen; three-wire adds eight control bits first.
// - Bits leave most significant first.
// - Serial clock rests low while idle.
// - Serial clock toggles only during a transfer.
// - Frame marker delimits each frame, except that back-to-back SPI words share one unbroken marker level.
// - Line driver enable gates external data driver.
// - Pulsed format: marker one period, from rise.
// - Pulsed format: drive on rise, sample on fall.
// - Three formats: pulsed, SPI, three-wire.
module ssfp_port
  import ssfp_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration, sampled when a frame starts
  input wire logic [1:0] fmt_sel,
  input wire logic [4:0] data_size,
  // Transmit word
  input wire logic tx_valid,
  input wire logic [WORD_MAX-1:0] tx_data,
  output logic tx_take,
  // Receive word
  output logic [WORD_MAX-1:0] rx_data,
  output logic rx_valid,
  // Serial pins
  output logic sclk,
  output logic txd,
  input wire logic rxd,
  output logic frame_marker,
  output logic line_driver_enable
);

  // ****************************************************************
  // State and decode
  // ****************************************************************
  localparam int MARK_CYCLES = 2 * HALF;

  ssfp_state_type state_q;
  logic [1:0] fmt_q;
  logic [4:0] size_q, bit_cnt_q, rx_cnt_q, size_in;
  logic [WORD_MAX-1:0] tx_sh_q, rx_sh_q, just;
  logic run_q, rx_act_q, rxd_m_q, rxd_s_q;
  logic sclk_q, txd_q, marker_q, lde_q, take_q, rxv_q;
  logic [WORD_MAX-1:0] rx_word_q;
  logic rise_en, fall_en, pulsed, launch_cap, last_bit;
  logic start, chain, spi_chain, mw_turn, pulse_load, done, shift_now;

  ssfp_clkdiv #(.HALF(HALF)) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run_q),
    .rise_en(rise_en),
    .fall_en(fall_en)
  );

  // Out of range sizes are clamped rather than producing a runt frame.
  assign size_in = (data_size < SIZE_MIN) ? SIZE_MIN :
                   (data_size > SIZE_MAX) ? SIZE_MAX : data_size;
  assign just = tx_data << (5'(WORD_MAX) - size_in);
  assign pulsed = (fmt_q == FMT_PULSED);
  assign launch_cap = pulsed ? fall_en : rise_en;
  assign last_bit = (bit_cnt_q == 5'h00);
  assign start = (state_q == ST_IDLE) && tx_valid;
  assign pulse_load = pulsed && rise_en && (state_q == ST_PULSE) && marker_q;
  assign chain = pulsed && rise_en && (state_q == ST_DATA) &&
                 (bit_cnt_q == 5'h01) && tx_valid;
  assign spi_chain = (fmt_q == FMT_SPI) && fall_en && (state_q == ST_DATA) &&
                     last_bit && tx_valid;
  assign mw_turn = (fmt_q == FMT_THREEWIRE) && fall_en && (state_q == ST_CTRL) &&
                   last_bit;
  assign done = (state_q == ST_DATA) && last_bit &&
                ((pulsed && rise_en) || (!pulsed && fall_en && !spi_chain));
  assign shift_now = (pulsed && rise_en && (state_q == ST_DATA) && !last_bit) ||
                     (!pulsed && fall_en && (state_q == ST_CTRL ||
                     (state_q == ST_DATA && !last_bit)));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      fmt_q <= FMT_PULSED;
      size_q <= SIZE_MIN;
      run_q <= 1'b0;
      lde_q <= 1'b0;
    end
    else if (start)
    begin
      fmt_q <= fmt_sel;
      size_q <= size_in;
      run_q <= 1'b1;
      lde_q <= 1'b1;
      unique case (fmt_sel)
        FMT_PULSED: state_q <= ST_PULSE;
        FMT_THREEWIRE: state_q <= ST_CTRL;
        default: state_q <= ST_DATA;
      endcase
    end
    else if (done)
    begin
      state_q <= ST_IDLE;
      run_q <= 1'b0;
      lde_q <= 1'b0;
    end
    else if (pulse_load || mw_turn)
    begin
      state_q <= ST_DATA;
    end
    else if (chain)
    begin
      state_q <= ST_PULSE;
    end
  end

  // ****************************************************************
  // Serial clock and frame marker
  // ****************************************************************
  // The closing rising slot of a pulsed frame is swallowed, so the clock
  // stops low straight after the last sampling edge.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sclk_q <= 1'b0;
    else if (rise_en && !done)
      sclk_q <= 1'b1;
    else if (fall_en)
      sclk_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      marker_q <= 1'b0;
    else if (start)
      marker_q <= (fmt_sel != FMT_PULSED);
    else if (done)
      marker_q <= 1'b0;
    else if (chain)
      marker_q <= 1'b1;
    else if (pulsed && rise_en && state_q == ST_PULSE)
      marker_q <= ~marker_q;
  end

  // ****************************************************************
  // Transmit shifter
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_q <= '0;
      txd_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      take_q <= 1'b0;
    end
    else
    begin
      take_q <= start || chain || spi_chain;
      if (start)
      begin
        if (fmt_sel == FMT_PULSED)
        begin
          tx_sh_q <= just;
          bit_cnt_q <= 5'h00;
        end
        else if (fmt_sel == FMT_THREEWIRE)
        begin
          txd_q <= tx_data[7];
          tx_sh_q <= {tx_data[6:0], 9'h000};
          bit_cnt_q <= CTRL_BITS - 5'h01;
        end
        else
        begin
          txd_q <= just[WORD_MAX-1];
          tx_sh_q <= {just[WORD_MAX-2:0], 1'b0};
          bit_cnt_q <= size_in - 5'h01;
        end
      end
      else if (chain)
      begin
        txd_q <= tx_sh_q[WORD_MAX-1];
        tx_sh_q <= just;
        bit_cnt_q <= 5'h00;
      end
      else if (spi_chain)
      begin
        txd_q <= just[WORD_MAX-1];
        tx_sh_q <= {just[WORD_MAX-2:0], 1'b0};
        bit_cnt_q <= size_q - 5'h01;
      end
      else if (pulse_load || mw_turn)
      begin
        txd_q <= tx_sh_q[WORD_MAX-1];
        tx_sh_q <= {tx_sh_q[WORD_MAX-2:0], 1'b0};
        bit_cnt_q <= size_q - 5'h01;
      end
      else if (shift_now)
      begin
        txd_q <= tx_sh_q[WORD_MAX-1];
        tx_sh_q <= {tx_sh_q[WORD_MAX-2:0], 1'b0};
        bit_cnt_q <= bit_cnt_q - 5'h01;
      end
      else if (done)
      begin
        txd_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Receive assembler
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_m_q <= 1'b0;
      rxd_s_q <= 1'b0;
    end
    else
    begin
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 5'h00;
      rx_sh_q <= '0;
      rx_word_q <= '0;
      rxv_q <= 1'b0;
    end
    else
    begin
      rxv_q <= 1'b0;
      if ((start && fmt_sel == FMT_SPI) || pulse_load || spi_chain || mw_turn)
      begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= 5'h00;
        rx_sh_q <= '0;
      end
      else if (rx_act_q && launch_cap)
      begin
        rx_sh_q <= {rx_sh_q[WORD_MAX-2:0], rxd_s_q};
        rx_cnt_q <= rx_cnt_q + 5'h01;
        if (rx_cnt_q == size_q - 5'h01)
        begin
          rx_word_q <= {rx_sh_q[WORD_MAX-2:0], rxd_s_q};
          rxv_q <= 1'b1;
          rx_act_q <= 1'b0;
        end
      end
    end
  end

  assign sclk = sclk_q;
  assign txd = txd_q;
  assign frame_marker = marker_q;
  assign line_driver_enable = lde_q;
  assign tx_take = take_q;
  assign rx_data = rx_word_q;
  assign rx_valid = rxv_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] mk_cnt_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mk_cnt_q <= 8'h00;
    else if (marker_q)
      mk_cnt_q <= mk_cnt_q + 8'h01;
    else
      mk_cnt_q <= 8'h00;
  end

  sequence mark_rise_s;
    pulsed && $rose(marker_q);
  endsequence

  sequence mark_fall_s;
    pulsed && $fell(marker_q);
  endsequence

  size_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q != ST_IDLE) |-> (size_q >= SIZE_MIN && size_q <= SIZE_MAX))
    else $error("frame size outside four to sixteen");

  msb_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    pulse_load |=> (txd_q == $past(tx_sh_q[WORD_MAX-1])))
    else $error("first data bit is not the top bit");

  idle_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_IDLE) && $past(state_q == ST_IDLE) |-> !sclk_q)
    else $error("serial clock high while idle");

  no_idle_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(sclk_q) |-> $past(run_q))
    else $error("serial clock moved outside a transfer");

  frame_mark_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!pulsed && state_q != ST_IDLE) |-> marker_q)
    else $error("marker dropped inside a select style frame");

  driver_en_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q != ST_IDLE) |-> lde_q)
    else $error("line driver disabled during a frame");

  mark_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    mark_fall_s |-> (mk_cnt_q == 8'(MARK_CYCLES)))
    else $error("frame pulse not one serial clock period");

  mark_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    mark_rise_s |-> $rose(sclk_q))
    else $error("frame pulse not aligned to a rising edge");

  drive_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
    (pulsed && $changed(txd_q) && $past(state_q) != ST_IDLE && state_q != ST_IDLE)
      |-> $rose(sclk_q))
    else $error("pulsed format data changed off a rising edge");

  chain_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    mark_rise_s ##0 ($past(state_q) == ST_DATA) |-> ($past(bit_cnt_q) == 5'h01))
    else $error("back to back pulse not in the last bit");

  rx_present_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxv_q |-> ($past(launch_cap) && !rx_act_q))
    else $error("received word presented away from a sampling edge");

endmodule // ssfp_port

// *** ssfp_pkg.sv ***
// Constants and types shared by the synchronous serial frame port.
// Assumes a single 100 MHz system clock drives every file of the port.
package ssfp_pkg;

  // ****************************************************************
  // Word and frame geometry
  // ****************************************************************
  localparam int WORD_MAX = 16;
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SIZE_MAX = 5'h10;
  localparam logic [4:0] CTRL_BITS = 5'h08;

  // ****************************************************************
  // Frame format codes on the format input
  // ****************************************************************
  localparam logic [1:0] FMT_PULSED = 2'h0;
  localparam logic [1:0] FMT_SPI = 2'h1;
  localparam logic [1:0] FMT_THREEWIRE = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int HALF_CYCLES = SCLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE,
    ST_CTRL,
    ST_DATA
  } ssfp_state_type;

endpackage

// *** ssfp_clkdiv.sv ***
// Serial clock divider for the synchronous serial frame port.
// Assumes run is a registered level on sys_clk; edges appear only while it is high.
`timescale 1ns/1ps
module ssfp_clkdiv
  import ssfp_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  // Edge enables
  output logic rise_en,
  output logic fall_en
);

  localparam logic [7:0] LAST = 8'(HALF - 1);

  logic [7:0] cnt_q;
  logic phase_q;
  logic tick;

  // Restarting from zero whenever run rises keeps the first rising edge a fixed
  // half period after the start, so no runt pulse can appear.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= 8'h00;
      phase_q <= ~phase_q;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick = run && (cnt_q == LAST);
  assign rise_en = tick && !phase_q;
  assign fall_en = tick && phase_q;

endmodule // ssfp_clkdiv

// *** ssfp_slave_model.sv ***
// Behavioural slave on the far side of the serial port.
// Assumes the pulsed-frame format; in other formats its data is ignored.
`timescale 1ns/1ps
module ssfp_slave_model
(
  // Serial pins
  input wire logic sclk,
  input wire logic frame_marker,
  input wire logic txd,
  output logic rxd,
  // Test control
  input wire logic [4:0] size,
  input wire logic [15:0] word,
  output logic [15:0] cap
);
  logic armed;
  int cnt;

  initial
  begin
    rxd = 1'b0;
    cap = 16'h0000;
    armed = 1'b0;
    cnt = 0;
  end

  // Capture on falling edges; arm after a frame pulse.
  always @(negedge sclk)
  begin
    cap <= {cap[14:0], txd};
    if (frame_marker)
    begin
      armed <= 1'b1;
    end
  end

  // Once hold time is over the line no longer shows the last bit.
  always @(negedge sclk)
  begin
    if (cnt == 0 && !armed && !frame_marker)
    begin
      rxd <= #30 ~rxd;
    end
  end

  // Drive on rising edges, most significant bit first.
  always @(posedge sclk)
  begin
    if (armed)
    begin
      rxd <= word[size-1];
      cnt <= size - 1;
      armed <= 1'b0;
    end
    else if (cnt != 0)
    begin
      rxd <= word[cnt-1];
      cnt <= cnt - 1;
    end
  end
endmodule // ssfp_slave_model

// *** tb_top.sv ***
// Self-checking bench for the serial frame port with a slave model.
// Assumes a 100 MHz sys_clk and a serial clock period of 160 ns.
`timescale 1ns/1ps
module tb_top;
  import ssfp_pkg::*;
  localparam int H = 8;
  logic sys_clk, rst, tx_valid, tx_take, rx_valid, sclk, txd, rxd;
  logic frame_marker, line_driver_enable, sclk_p, lde_p;
  logic [1:0] fmt_sel;
  logic [4:0] data_size;
  logic [15:0] tx_data, rx_data, cap, sw;
  logic [15:0] rxq[$];
  logic [15:0] capq[$];
  int mismatches, checks_done, rises, mk, off_edges;

  ssfp_port #(.HALF(H)) uut (.sys_clk(sys_clk), .rst(rst), .fmt_sel(fmt_sel),
    .data_size(data_size), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take),
    .rx_data(rx_data), .rx_valid(rx_valid), .sclk(sclk), .txd(txd), .rxd(rxd),
    .frame_marker(frame_marker), .line_driver_enable(line_driver_enable));
  ssfp_slave_model slave (.sclk(sclk), .frame_marker(frame_marker), .txd(txd),
    .rxd(rxd), .size(data_size), .word(sw), .cap(cap));

  always #5 sys_clk = ~sys_clk;

  // ****************************************************************
  // Line monitor
  // ****************************************************************
  always @(posedge sys_clk)
  begin
    if (sclk === 1'b1 && sclk_p === 1'b0)
      rises++;
    if (sclk !== sclk_p && !line_driver_enable && !lde_p)
      off_edges++;
    if (frame_marker === 1'b1)
      mk++;
    if (rx_valid === 1'b1)
    begin
      rxq.push_back(rx_data);
      capq.push_back(cap);
    end
    sclk_p = sclk;
    lde_p = line_driver_enable;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Sends n words back to back in one format, then judges the line.
  task automatic do_frames(input logic [1:0] fmt, input logic [4:0] size, input int n,
                           input int exp_rises);
    logic [15:0] mask;
    int i;
    int t;
    mask = 16'((17'h1 << size) - 1);
    i = 0;
    rises = 0;
    mk = 0;
    off_edges = 0;
    rxq.delete();
    capq.delete();
    @(posedge sys_clk);
    fmt_sel <= fmt;
    data_size <= size;
    tx_valid <= 1'b1;
    tx_data <= 16'h9e37;
    while (i < n)
    begin
      t = 0;
      while (tx_take !== 1'b1)
      begin
        @(posedge sys_clk);
        t++;
        if (t > 1000)
        begin
          mismatches++;
          complete_run();
        end
      end
      i++;
      if (i < n)
        tx_data <= 16'h9e37 ^ 16'(i * 16'h3c5a);
      else
        tx_valid <= 1'b0;
      @(posedge sys_clk);
    end
    t = 0;
    while (line_driver_enable !== 1'b0)
    begin
      @(posedge sys_clk);
      t++;
      if (t > 1000)
      begin
        mismatches++;
        complete_run();
      end
    end
    repeat (4) @(posedge sys_clk);
    check(16'(rises), 16'(exp_rises));
    check(16'(off_edges), 16'h0000);
    check({15'h0000, sclk}, 16'h0000);
    check({15'h0000, frame_marker}, 16'h0000);
    check(16'(rxq.size()), 16'(n));
    if (fmt == FMT_PULSED)
    begin
      check(16'(mk), 16'(n * 2 * H));
      for (int k = 0; k < n && k < rxq.size(); k++)
      begin
        check(rxq[k], sw & mask);
        check(capq[k] & mask, (16'h9e37 ^ 16'(k * 16'h3c5a)) & mask);
      end
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Shortest pulsed frame: four bits, one frame pulse.
  task automatic pulsed_shortest;
    sw = 16'ha5c3;
    do_frames(FMT_PULSED, 5'h04, 1, 5);
  endtask

  // Longest pulsed frame: sixteen bits, whole word both ways.
  task automatic pulsed_longest;
    sw = 16'h5a3c;
    do_frames(FMT_PULSED, 5'h10, 1, 17);
  endtask

  // Three pulsed frames with no gap; the second and third pulses ride on a last bit.
  task automatic pulsed_chained;
    sw = 16'h5a3c;
    do_frames(FMT_PULSED, 5'h08, 3, 25);
  endtask

  // Select style frame; only the line and word count are judged.
  task automatic spi_single;
    do_frames(FMT_SPI, 5'h05, 1, 5);
  endtask

  // Eight control bits out, then four data bits in.
  task automatic threewire_single;
    do_frames(FMT_THREEWIRE, 5'h04, 1, 12);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    fmt_sel = FMT_PULSED;
    data_size = 5'h08;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    sw = 16'ha5c3;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pulsed_shortest();
    pulsed_longest();
    pulsed_chained();
    spi_single();
    threewire_single();
    complete_run();
  end
endmodule // tb_top
